// file: design/mdu_pkg.sv
// Package with register offsets, control field positions and timing counts for the arithmetic unit.
`default_nettype none
package mdu_pkg;
  localparam logic [3:0] OFS_A_LOW      = 4'h0;
  localparam logic [3:0] OFS_A_HIGH     = 4'h1;
  localparam logic [3:0] OFS_B_LOW      = 4'h2;
  localparam logic [3:0] OFS_B_HIGH     = 4'h3;
  localparam logic [3:0] OFS_C_LOW      = 4'h4;
  localparam logic [3:0] OFS_C_HIGH     = 4'h5;
  localparam logic [3:0] OFS_CONTROL    = 4'h6;
  localparam int         BIT_DIVIDE     = 7;
  localparam int         BIT_ACCUM      = 6;
  localparam int         BIT_SIGNED     = 3;
  localparam int         BIT_OVERFLOW   = 2;
  localparam int         BIT_SIGN       = 1;
  localparam int         BIT_START      = 0;
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [15:0] DATA_RESET    = 16'h0000;
  localparam logic [7:0] CONTROL_WMASK  = 8'hc8;
  localparam logic [5:0] DIV_STEPS      = 6'h20;
  localparam int         DATA_W         = 16;
endpackage
`default_nettype wire

// file: design/mdu_divider.sv
// Iterative restoring divider, one quotient bit per clock.
`default_nettype none
module mdu_divider
  import mdu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire logic [31:0] dividend_i,
  input  wire logic [31:0] divisor_i,
  output logic             done_o,
  output logic [31:0]      quotient_o,
  output logic [31:0]      remainder_o
);
  logic [5:0]  count;
  logic [5:0]  next_count;
  logic [31:0] quo;
  logic [31:0] next_quo;
  logic [31:0] rem;
  logic [31:0] next_rem;
  logic [31:0] dsr;
  logic [31:0] next_dsr;
  logic        done;
  logic        next_done;
  logic [33:0] trial;

  always_comb begin
    next_count = count;
    next_quo   = quo;
    next_rem   = rem;
    next_dsr   = dsr;
    next_done  = 1'b0;
    trial      = {1'b0, rem, quo[31]} - {2'b00, dsr};
    if (start_i) begin
      next_count = DIV_STEPS;
      next_quo   = dividend_i;
      next_rem   = 32'h0000_0000;
      next_dsr   = divisor_i;
    end else if (count != 6'h00) begin
      if (trial[33]) begin
        next_rem = {rem[30:0], quo[31]};
        next_quo = {quo[30:0], 1'b0};
      end else begin
        next_rem = trial[31:0];
        next_quo = {quo[30:0], 1'b1};
      end
      next_count = count - 6'h01;
      next_done  = (count == 6'h01);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= 6'h00;
      quo   <= 32'h0000_0000;
      rem   <= 32'h0000_0000;
      dsr   <= 32'h0000_0000;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      quo   <= next_quo;
      rem   <= next_rem;
      dsr   <= next_dsr;
      done  <= next_done;
    end
  end

  assign done_o      = done;
  assign quotient_o  = quo;
  assign remainder_o = rem;
endmodule
`default_nettype wire

// file: design/mdu_core.sv
// Memory-mapped multiply, multiply-accumulate and divide unit with its register file.
`default_nettype none
module mdu_core
  import mdu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        write_i,
  input  wire logic        read_i,
  output logic [15:0]      rdata_o,
  output logic             arith_interrupt_o
);
  typedef enum logic [1:0] {MDU_IDLE, MDU_MUL, MDU_ACC, MDU_DIV} mdu_state_e;

  mdu_state_e  state;
  mdu_state_e  next_state;
  logic [15:0] a_high;
  logic [15:0] next_a_high;
  logic [15:0] a_low;
  logic [15:0] next_a_low;
  logic [15:0] b_high;
  logic [15:0] next_b_high;
  logic [15:0] b_low;
  logic [15:0] next_b_low;
  logic [15:0] c_high;
  logic [15:0] next_c_high;
  logic [15:0] c_low;
  logic [15:0] next_c_low;
  logic [7:0]  control;
  logic [7:0]  next_control;
  logic        low_written;
  logic        next_low_written;
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  logic        irq;
  logic        next_irq;
  logic [31:0] product;
  logic [32:0] sum_u;
  logic [31:0] sum_s;
  logic        ovf;
  logic        div_start;
  logic        div_done;
  logic [31:0] div_quo;
  logic [31:0] div_rem;

  function automatic logic is_write(input logic [3:0] a, input logic [3:0] ofs, input logic we);
    is_write = we && (a == ofs);
  endfunction

  wire logic divide_select     = control[BIT_DIVIDE];
  wire logic accumulate_select = control[BIT_ACCUM];
  wire logic signed_select     = control[BIT_SIGNED];

  // Product in selected signedness.
  always_comb begin
    if (signed_select) begin
      product = 32'($signed({{16{a_low[15]}}, a_low}) * $signed({{16{a_high[15]}}, a_high}));
    end else begin
      product = {16'h0000, a_low} * {16'h0000, a_high};
    end
    sum_u = {1'b0, b_high, b_low} + {1'b0, c_high, c_low};
    sum_s = sum_u[31:0];
    if (signed_select) begin
      ovf = (b_high[15] == c_high[15]) && (sum_s[31] != b_high[15]);
    end else begin
      ovf = sum_u[32];
    end
  end

  mdu_divider u_div (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .start_i     (div_start),
    .dividend_i  ({a_high, a_low}),
    .divisor_i   ({b_high, b_low}),
    .done_o      (div_done),
    .quotient_o  (div_quo),
    .remainder_o (div_rem)
  );

  always_comb begin
    next_state       = state;
    next_a_high      = a_high;
    next_a_low       = a_low;
    next_b_high      = b_high;
    next_b_low       = b_low;
    next_c_high      = c_high;
    next_c_low       = c_low;
    next_control     = control;
    next_low_written = low_written;
    next_irq         = 1'b0;
    div_start        = 1'b0;
    // Software writes: data registers take all 16 bits, control takes only its writable bits 7, 6 and 3.
    if (is_write(addr_i, OFS_A_LOW, write_i)) begin
      next_a_low       = wdata_i;
      next_low_written = 1'b1;
    end
    if (is_write(addr_i, OFS_A_HIGH, write_i)) begin
      next_a_high = wdata_i;
    end
    if (is_write(addr_i, OFS_B_LOW, write_i)) begin
      next_b_low = wdata_i;
    end
    if (is_write(addr_i, OFS_B_HIGH, write_i)) begin
      next_b_high = wdata_i;
    end
    if (is_write(addr_i, OFS_C_LOW, write_i)) begin
      next_c_low = wdata_i;
    end
    if (is_write(addr_i, OFS_C_HIGH, write_i)) begin
      next_c_high = wdata_i;
    end
    if (is_write(addr_i, OFS_CONTROL, write_i)) begin
      next_control = (control & ~CONTROL_WMASK) | (wdata_i[7:0] & CONTROL_WMASK);
      if (!wdata_i[BIT_ACCUM] && !wdata_i[BIT_DIVIDE]) begin
        next_control[BIT_OVERFLOW] = 1'b0;
        next_control[BIT_SIGN]     = 1'b0;
      end
      // Start bit is set only in divide mode and cannot be cleared while busy.
      if (state != MDU_DIV && wdata_i[BIT_DIVIDE] && wdata_i[BIT_START]) begin
        next_control[BIT_START] = 1'b1;
        div_start               = 1'b1;
        next_state              = MDU_DIV;
      end
    end
    // Multiply starts on any write of the high half outside divide mode, except in the MDU_MUL cycle; low_written is not checked.
    if (is_write(addr_i, OFS_A_HIGH, write_i) && !divide_select && state != MDU_DIV) begin
      next_state = MDU_MUL;
    end
    case (state)
      MDU_IDLE: begin
      end
      MDU_MUL: begin
        next_b_high = product[31:16];
        next_b_low  = product[15:0];
        if (next_state == MDU_MUL) begin
          next_state = accumulate_select ? MDU_ACC : MDU_IDLE;
        end
      end
      MDU_ACC: begin
        next_c_high = sum_u[31:16];
        next_c_low  = sum_u[15:0];
        next_control[BIT_SIGN] = signed_select & sum_s[31];
        if (ovf) begin
          next_control[BIT_OVERFLOW] = 1'b1;
          next_irq                   = 1'b1;
        end
        if (next_state == MDU_ACC) begin
          next_state = MDU_IDLE;
        end
      end
      MDU_DIV: begin
        next_control[BIT_START] = 1'b1;
        // Quotient and remainder shift in place, so A and C show partial values.
        next_a_high = div_quo[31:16];
        next_a_low  = div_quo[15:0];
        next_c_high = div_rem[31:16];
        next_c_low  = div_rem[15:0];
        if (div_done) begin
          next_control[BIT_START] = 1'b0;
          next_irq                = !accumulate_select;
          next_state              = MDU_IDLE;
        end
      end
      default: begin
        next_state = MDU_IDLE;
      end
    endcase
    if (next_state != MDU_MUL && state == MDU_MUL) begin
      next_low_written = 1'b0;
    end
  end

  // Read data one cycle after the read strobe; unmapped reads give zero.
  always_comb begin
    next_rdata = 16'h0000;
    if (read_i) begin
      case (addr_i)
        OFS_A_LOW:   next_rdata = a_low;
        OFS_A_HIGH:  next_rdata = a_high;
        OFS_B_LOW:   next_rdata = b_low;
        OFS_B_HIGH:  next_rdata = b_high;
        OFS_C_LOW:   next_rdata = c_low;
        OFS_C_HIGH:  next_rdata = c_high;
        OFS_CONTROL: next_rdata = {8'h00, control};
        default:     next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state       <= MDU_IDLE;
      a_high      <= DATA_RESET;
      a_low       <= DATA_RESET;
      b_high      <= DATA_RESET;
      b_low       <= DATA_RESET;
      c_high      <= DATA_RESET;
      c_low       <= DATA_RESET;
      control     <= CONTROL_RESET;
      low_written <= 1'b0;
      rdata       <= 16'h0000;
      irq         <= 1'b0;
    end else begin
      state       <= next_state;
      a_high      <= next_a_high;
      a_low       <= next_a_low;
      b_high      <= next_b_high;
      b_low       <= next_b_low;
      c_high      <= next_c_high;
      c_low       <= next_c_low;
      control     <= next_control;
      low_written <= next_low_written;
      rdata       <= next_rdata;
      irq         <= next_irq;
    end
  end

  assign rdata_o           = rdata;
  assign arith_interrupt_o = irq;
endmodule
`default_nettype wire

// file: tb/mdu_core_chk.sv
// Assertions on the arithmetic unit's ports.
`default_nettype none
module mdu_core_chk
  import mdu_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        write_i,
  input wire logic        read_i,
  input wire logic [15:0] rdata_o,
  input wire logic        arith_interrupt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic cw;
  assign cw = write_i && addr_i == OFS_CONTROL;
  idle_zero_a: assert property (!read_i |=> rdata_o == 16'h0000)
    else $error("idle read data");
  unmapped_zero_a: assert property (read_i && addr_i > OFS_CONTROL |=> rdata_o == 16'h0000)
    else $error("unmapped read data");
  reserved_zero_a: assert property (
    read_i && addr_i == OFS_CONTROL |=> rdata_o[15:8] == 8'h00 && rdata_o[5:4] == 2'h0)
    else $error("reserved control bits");
  a_back_a: assert property (
    write_i && addr_i <= OFS_A_HIGH ##1 read_i && addr_i == $past(addr_i) |=> rdata_o == $past(wdata_i, 2))
    else $error("operand readback");
  c_back_a: assert property (
    write_i && (addr_i == OFS_C_LOW || addr_i == OFS_C_HIGH) ##1 read_i && addr_i == $past(addr_i)
    |=> rdata_o == $past(wdata_i, 2))
    else $error("accumulator readback");
  ctl_back_a: assert property (
    cw && wdata_i[7:6] == 2'b00 ##1 read_i && addr_i == OFS_CONTROL
    |=> rdata_o == {12'h000, $past(wdata_i[3], 2), 3'h0})
    else $error("control readback");
  start_set_a: assert property (
    cw && wdata_i[7] && wdata_i[0] ##1 read_i && addr_i == OFS_CONTROL |=> rdata_o[0])
    else $error("start bit not set");
  div_done_a: assert property (
    cw && wdata_i[7:6] == 2'b10 && wdata_i[0] |=> !arith_interrupt_o [*8] ##[1:40] arith_interrupt_o)
    else $error("divide completion pulse");
endmodule
bind mdu_core mdu_core_chk mdu_core_chk_i (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
  .arith_interrupt_o(arith_interrupt_o));
`default_nettype wire

// file: tb/test_mdu_core.sv
// Self-checking bench for the arithmetic unit.
`default_nettype none
module test_mdu_core
  import mdu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        write_i = 1'b0;
  logic        read_i = 1'b0;
  logic [15:0] rdata_o;
  logic        arith_interrupt_o;
  logic [15:0] v;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_int = 0;
  mdu_core mdu_core_i (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .arith_interrupt_o(arith_interrupt_o));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (arith_interrupt_o === 1'b1) n_int++;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    write_i <= w;
    read_i <= r;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    bus(1'b0, 1'b1, a, 16'h0000);
    q = rdata_o;
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 16'h0000);
  endtask
  task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
    rd(a, v);
    chk(what, exp, v);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 7; i++) rchk("reset value", i[3:0], 16'h0000);
    rchk("unmapped", 4'hf, 16'h0000);
    wr(OFS_C_LOW, 16'h1234);
    rchk("c low", OFS_C_LOW, 16'h1234);
    wr(OFS_C_HIGH, 16'h5678);
    rchk("c high", OFS_C_HIGH, 16'h5678);
    $display("reset test done");
  endtask
  task automatic t_mul();
    logic [71:0] tv [4] = '{72'h00_0002_0003_00000006, 72'h00_ffff_ffff_fffe0001,
                            72'h08_fffe_7fff_ffff0002, 72'h08_8000_8000_40000000};
    foreach (tv[i]) begin
      wr(OFS_CONTROL, {8'h00, tv[i][71:64]});
      rchk("control", OFS_CONTROL, {8'h00, tv[i][71:64]});
      wr(OFS_A_LOW, tv[i][63:48]);
      wr(OFS_A_HIGH, tv[i][47:32]);
      rchk("a high", OFS_A_HIGH, tv[i][47:32]);
      idle(1);
      rchk("b low", OFS_B_LOW, tv[i][15:0]);
      rchk("b high", OFS_B_HIGH, tv[i][31:16]);
    end
    rchk("c kept", OFS_C_LOW, 16'h1234);
    $display("multiply test done");
  endtask
  task automatic mac(input logic [7:0] m, input logic [31:0] c, input logic [15:0] al,
                     input logic [15:0] ah, input logic [31:0] p, input logic [31:0] s,
                     input logic [15:0] f);
    wr(OFS_CONTROL, {8'h00, m});
    wr(OFS_C_LOW, c[15:0]);
    wr(OFS_C_HIGH, c[31:16]);
    wr(OFS_A_LOW, al);
    wr(OFS_A_HIGH, ah);
    idle(3);
    rchk("mac b low", OFS_B_LOW, p[15:0]);
    rchk("mac b high", OFS_B_HIGH, p[31:16]);
    rchk("mac c low", OFS_C_LOW, s[15:0]);
    rchk("mac c high", OFS_C_HIGH, s[31:16]);
    rchk("flags", OFS_CONTROL, {8'h00, m} | f);
  endtask
  task automatic t_mac();
    int k;
    k = n_int;
    mac(8'h40, 32'h3, 16'h2, 16'h3, 32'h6, 32'h9, 16'h0);
    mac(8'h40, 32'hffff0002, 16'h7fff, 16'h2, 32'hfffe, 32'h0, 16'h4);
    chk("mac pulses", 16'h0001, 16'(n_int - k));
    wr(OFS_CONTROL, 16'h0008);
    mac(8'h48, 32'h0, 16'hfffe, 16'h3, 32'hfffffffa, 32'hfffffffa, 16'h2);
    $display("accumulate test done");
  endtask
  task automatic div(input logic [7:0] m, input logic [31:0] n, input logic [31:0] d, input int ni);
    int k;
    logic [31:0] q;
    logic [31:0] r;
    k = n_int;
    q = n / d;
    r = n % d;
    wr(OFS_CONTROL, 16'h0000);
    wr(OFS_CONTROL, {8'h00, m});
    wr(OFS_A_LOW, n[15:0]);
    wr(OFS_A_HIGH, n[31:16]);
    wr(OFS_B_LOW, d[15:0]);
    wr(OFS_B_HIGH, d[31:16]);
    wr(OFS_CONTROL, {8'h00, m | 8'h01});
    rchk("busy", OFS_CONTROL, {8'h00, m | 8'h01});
    wr(OFS_CONTROL, {8'h00, m});
    rchk("busy kept", OFS_CONTROL, {8'h00, m | 8'h01});
    for (int i = 0; i < 60 && v[0] !== 1'b0; i++) rd(OFS_CONTROL, v);
    chk("done", {8'h00, m}, v);
    if (v[0] !== 1'b0) stop_test();
    rchk("quot low", OFS_A_LOW, q[15:0]);
    rchk("quot high", OFS_A_HIGH, q[31:16]);
    rchk("rem low", OFS_C_LOW, r[15:0]);
    rchk("rem high", OFS_C_HIGH, r[31:16]);
    chk("div pulses", 16'(ni), 16'(n_int - k));
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    t_reset();
    t_mul();
    t_mac();
    div(8'h80, 32'h000186a0, 32'h7, 1);
    div(8'hc0, 32'hffffffff, 32'h00010000, 0);
    $display("divide test done");
    stop_test();
  end
endmodule
`default_nettype wire
